/* rtl/mbox_reset_hs.sv */
/*
 * Mailbox between host software and management firmware: control and
 * status registers of both sides, two circular buffers with windows,
 * interface reset and ready handshake, pointer-clear interlock.
 * Assumes one APB master carrying both host and firmware accesses,
 * one clock and a synchronous active-high reset.
 */
// Chosen here: register access over APB and the address map.
// Summary of operation
// - Host reset rising clears both ready flags
// - Host generate sets firmware status, interrupt if enabled
// - Pointer-clear zeroes all four buffer pointers
// - Pointer-clear self-clears only after pointers zeroed
// - Firmware polls; clearing done within ten cycles
// - Firmware generate sets host status, ready copy
// - Final host generate interrupts firmware again
// - Firmware window writes discarded while not ready
// - Read window gives ones, pointer held, not ready
`include "mbox_cfg.svh"

module mbox_reset_hs import mbox_pkg::*; #(
	parameter int BUF_WORDS = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt lines
	output logic fw_irq,
	output logic host_irq
);

	localparam int AW = $clog2(BUF_WORDS);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic host_ie_q, host_ie_d;
	logic host_is_q, host_is_d;
	logic host_rdy_q, host_rdy_d;
	logic host_rst_q, host_rst_d;
	logic fw_ie_q, fw_ie_d;
	logic fw_is_q, fw_is_d;
	logic fw_rdy_q, fw_rdy_d;
	logic fw_rst_q, fw_rst_d;
	logic pclr_q, pclr_d;
	logic req_q, req_d;
	pclr_state_e pc_q, pc_d;
	logic [7:0] fw_depth_q, fw_depth_d;
	logic [7:0] host_depth_q, host_depth_d;
	logic [7:0] host_rp_q, host_rp_d;
	logic [7:0] host_wp_q, host_wp_d;
	logic [7:0] fw_rp_q, fw_rp_d;
	logic [7:0] fw_wp_q, fw_wp_d;
	logic fw_irq_q, fw_irq_d;
	logic host_irq_q, host_irq_d;
	logic [31:0] fw_mem [BUF_WORDS];
	logic [31:0] host_mem [BUF_WORDS];
	logic fw_we, host_we;
	logic ack_in, far_clear;
	logic acc, wr, rd;
	logic [31:0] host_csr_rd, fw_csr_rd;

	// ------------------------------------------------------------
	// Pointer-clear crossing
	// ------------------------------------------------------------
	clear_handshake u_clear (
		.ref_clk(ref_clk),
		.reset(reset),
		.req_in(req_q),
		.ack_out(ack_in),
		.far_clear(far_clear)
	);

	// ------------------------------------------------------------
	// Read views of both control registers
	// ------------------------------------------------------------
	always_comb begin
		host_csr_rd = '0;
		host_csr_rd[`BIT_IE] = host_ie_q;
		host_csr_rd[`BIT_IS] = host_is_q;
		host_csr_rd[`BIT_RDY] = host_rdy_q;
		host_csr_rd[`BIT_RST] = host_rst_q;
		host_csr_rd[`FLD_RP_LSB +: 8] = host_rp_q;
		host_csr_rd[`FLD_WP_LSB +: 8] = host_wp_q;
		host_csr_rd[`FLD_DEPTH_LSB +: 8] = host_depth_q;
		fw_csr_rd = '0;
		fw_csr_rd[`BIT_IE] = fw_ie_q;
		fw_csr_rd[`BIT_IS] = fw_is_q;
		fw_csr_rd[`BIT_RDY] = fw_rdy_q;
		fw_csr_rd[`BIT_RST] = fw_rst_q;
		fw_csr_rd[`FLD_RP_LSB +: 8] = fw_rp_q;
		fw_csr_rd[`FLD_WP_LSB +: 8] = fw_wp_q;
		fw_csr_rd[`FLD_DEPTH_LSB +: 8] = fw_depth_q;
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		// Effects land at the edge where the master samples pready
		acc = psel & penable & pready_q;
		wr = acc & pwrite;
		rd = acc & ~pwrite;
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		host_ie_d = host_ie_q;
		host_is_d = host_is_q;
		host_rdy_d = host_rdy_q;
		host_rst_d = host_rst_q;
		fw_ie_d = fw_ie_q;
		fw_is_d = fw_is_q;
		fw_rdy_d = fw_rdy_q;
		fw_rst_d = fw_rst_q;
		pclr_d = pclr_q;
		req_d = req_q;
		pc_d = pc_q;
		fw_depth_d = fw_depth_q;
		host_depth_d = host_depth_q;
		host_rp_d = host_rp_q;
		host_wp_d = host_wp_q;
		fw_rp_d = fw_rp_q;
		fw_wp_d = fw_wp_q;
		fw_we = 1'b0;
		host_we = 1'b0;

		// Data prepared for every access, so a refused one shows zero
		if (pready_d) begin
			case (paddr)
				`OFS_HOST_CSR: prdata_d = host_csr_rd;
				`OFS_FW_HOST_VIEW: prdata_d = fw_csr_rd;
				`OFS_HOST_FW_VIEW: prdata_d = host_csr_rd;
				`OFS_FW_CSR: begin
					prdata_d = fw_csr_rd;
					prdata_d[`BIT_PCLR] = pclr_q;
				end
				`OFS_DEPTH: begin
					prdata_d = '0;
					prdata_d[7:0] = fw_depth_q;
					prdata_d[`FLD_HDEPTH_LSB +: 8] = host_depth_q;
				end
				`OFS_FW_RD_WIN: begin
					prdata_d = fw_rdy_q ? fw_mem[fw_rp_q[AW-1:0]] :
						`ALL_ONES;
				end
				`OFS_HOST_RD_WIN: begin
					prdata_d = fw_rdy_q ? host_mem[host_rp_q[AW-1:0]] :
						`ALL_ONES;
				end
				`OFS_FW_WR_WIN, `OFS_HOST_WR_WIN: prdata_d = '0;
				default: prdata_d = '0;
			endcase
		end
		if (pready_d) begin
			case (paddr)
				`OFS_HOST_CSR, `OFS_FW_HOST_VIEW, `OFS_FW_RD_WIN,
				`OFS_HOST_FW_VIEW, `OFS_FW_CSR, `OFS_FW_WR_WIN,
				`OFS_DEPTH, `OFS_HOST_WR_WIN,
				`OFS_HOST_RD_WIN: pslverr_d = 1'b0;
				default: pslverr_d = 1'b1;
			endcase
		end

		// Software clears first, so a hardware set in the same cycle wins
		if (wr && paddr == `OFS_HOST_CSR) begin
			host_ie_d = pwdata[`BIT_IE];
			if (pwdata[`BIT_IS])
				host_is_d = 1'b0;
			host_rdy_d = pwdata[`BIT_RDY];
			host_rst_d = pwdata[`BIT_RST];
			if (pwdata[`BIT_IG])
				fw_is_d = 1'b1;
			if (pwdata[`BIT_RST] && !host_rst_q) begin
				host_rdy_d = 1'b0;
				fw_rdy_d = 1'b0;
			end
		end
		if (wr && paddr == `OFS_FW_CSR) begin
			fw_ie_d = pwdata[`BIT_IE];
			if (pwdata[`BIT_IS])
				fw_is_d = 1'b0;
			if (!(pwdata[`BIT_RST] && !host_rst_q && host_rst_d))
				fw_rdy_d = pwdata[`BIT_RDY];
			fw_rst_d = pwdata[`BIT_RST];
			// Ready copy in the host view follows at once
			if (pwdata[`BIT_IG])
				host_is_d = 1'b1;
			if (pwdata[`BIT_PCLR])
				pclr_d = 1'b1;
		end
		// Depth rewrites are not interlocked; firmware keeps them idle
		if (wr && paddr == `OFS_DEPTH) begin
			fw_depth_d = pwdata[7:0];
			host_depth_d = pwdata[`FLD_HDEPTH_LSB +: 8];
		end

		// Buffer windows: all dead while firmware is not ready
		if (wr && paddr == `OFS_FW_WR_WIN && fw_rdy_q) begin
			fw_we = 1'b1;
			fw_wp_d = fw_wp_q + 8'h01;
		end
		if (rd && paddr == `OFS_FW_RD_WIN && fw_rdy_q)
			fw_rp_d = fw_rp_q + 8'h01;
		if (wr && paddr == `OFS_HOST_WR_WIN && fw_rdy_q) begin
			host_we = 1'b1;
			host_wp_d = host_wp_q + 8'h01;
		end
		if (rd && paddr == `OFS_HOST_RD_WIN && fw_rdy_q)
			host_rp_d = host_rp_q + 8'h01;

		// Host-side pointers cleared when the request arrives there
		if (far_clear) begin
			host_rp_d = `POINTER_CLEAR_VAL;
			host_wp_d = `POINTER_CLEAR_VAL;
		end

		// Bit stays set until the far side has acknowledged
		case (pc_q)
			PC_IDLE: begin
				if (pclr_d) begin
					req_d = 1'b1;
					pc_d = PC_REQ;
				end
			end
			PC_REQ: begin
				if (ack_in) begin
					fw_rp_d = `POINTER_CLEAR_VAL;
					fw_wp_d = `POINTER_CLEAR_VAL;
					pclr_d = 1'b0;
					req_d = 1'b0;
					pc_d = PC_DROP;
				end
			end
			PC_DROP: begin
				// A new request waits for the old acknowledge to fall
				if (!ack_in) begin
					pc_d = pclr_d ? PC_REQ : PC_IDLE;
					req_d = pclr_d;
				end
			end
			default: begin
				pc_d = PC_IDLE;
				req_d = 1'b0;
			end
		endcase

		fw_irq_d = fw_is_d & fw_ie_d;
		host_irq_d = host_is_d & host_ie_d;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			host_ie_q <= 1'b0;
			host_is_q <= 1'b0;
			host_rdy_q <= 1'b0;
			host_rst_q <= 1'b0;
			fw_ie_q <= 1'b0;
			fw_is_q <= 1'b0;
			fw_rdy_q <= 1'b0;
			fw_rst_q <= 1'b0;
			pclr_q <= 1'b0;
			req_q <= 1'b0;
			pc_q <= PC_IDLE;
			fw_depth_q <= `FW_DEPTH_RST;
			host_depth_q <= `HOST_DEPTH_RST;
			host_rp_q <= `POINTER_CLEAR_VAL;
			host_wp_q <= `POINTER_CLEAR_VAL;
			fw_rp_q <= `POINTER_CLEAR_VAL;
			fw_wp_q <= `POINTER_CLEAR_VAL;
			fw_irq_q <= 1'b0;
			host_irq_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			host_ie_q <= host_ie_d;
			host_is_q <= host_is_d;
			host_rdy_q <= host_rdy_d;
			host_rst_q <= host_rst_d;
			fw_ie_q <= fw_ie_d;
			fw_is_q <= fw_is_d;
			fw_rdy_q <= fw_rdy_d;
			fw_rst_q <= fw_rst_d;
			pclr_q <= pclr_d;
			req_q <= req_d;
			pc_q <= pc_d;
			fw_depth_q <= fw_depth_d;
			host_depth_q <= host_depth_d;
			host_rp_q <= host_rp_d;
			host_wp_q <= host_wp_d;
			fw_rp_q <= fw_rp_d;
			fw_wp_q <= fw_wp_d;
			fw_irq_q <= fw_irq_d;
			host_irq_q <= host_irq_d;
		end
	end

	// Buffer storage needs no reset
	always_ff @(posedge ref_clk) begin
		if (fw_we)
			fw_mem[fw_wp_q[AW-1:0]] <= pwdata;
		if (host_we)
			host_mem[host_wp_q[AW-1:0]] <= pwdata;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign fw_irq = fw_irq_q;
	assign host_irq = host_irq_q;

endmodule

/* rtl/mbox_cfg.svh */
/*
 * Register offsets, field positions and reset values of the mailbox
 * reset handshake block. Assumes inclusion by bare name from rtl/.
 */
`ifndef MBOX_CFG_SVH
`define MBOX_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_HOST_CSR 8'h00
`define OFS_FW_HOST_VIEW 8'h04
`define OFS_FW_RD_WIN 8'h08
`define OFS_HOST_FW_VIEW 8'h0C
`define OFS_FW_CSR 8'h10
`define OFS_FW_WR_WIN 8'h14
`define OFS_DEPTH 8'h18
`define OFS_HOST_WR_WIN 8'h1C
`define OFS_HOST_RD_WIN 8'h20

// ------------------------------------------------------------
// Control and status field positions
// ------------------------------------------------------------
`define BIT_IE 0
`define BIT_IS 1
`define BIT_IG 2
`define BIT_RDY 3
`define BIT_RST 4
`define BIT_PCLR 5
`define FLD_RP_LSB 8
`define FLD_WP_LSB 16
`define FLD_DEPTH_LSB 24
`define FLD_HDEPTH_LSB 8

// ------------------------------------------------------------
// Reset values and the not-ready read pattern
// ------------------------------------------------------------
`define FW_DEPTH_RST 8'h02
`define HOST_DEPTH_RST 8'h02
`define POINTER_CLEAR_VAL 8'h00
`define ALL_ONES 32'hFFFFFFFF

`endif

/* rtl/mbox_pkg.sv */
/*
 * Types shared by the mailbox reset handshake block.
 * Assumes nothing of its surroundings.
 */
package mbox_pkg;

	// Pointer-clear sequencing on the firmware side
	typedef enum logic [2:0] {
		PC_IDLE = 3'b001,
		PC_REQ = 3'b010,
		PC_DROP = 3'b100
	} pclr_state_e;

endpackage

/* rtl/clear_handshake.sv */
/*
 * Four-phase request/acknowledge link that carries the pointer-clear
 * request to the host-side pointers and returns completion.
 * Assumes req_in is a level held until ack_out rises, then dropped.
 */
module clear_handshake (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Near (firmware) side
	input wire logic req_in,
	output logic ack_out,
	// Far (host) side
	output logic far_clear
);

	logic req_s1_q, req_s1_d;
	logic req_s2_q, req_s2_d;
	logic ack_q, ack_d;
	logic ack_s1_q, ack_s1_d;
	logic ack_s2_q, ack_s2_d;
	logic clr_q, clr_d;

	always_comb begin
		req_s1_d = req_in;
		req_s2_d = req_s1_q;
		// Far side clears in the cycle after it first sees the request
		clr_d = req_s2_q & ~ack_q;
		ack_d = req_s2_q;
		ack_s1_d = ack_q;
		ack_s2_d = ack_s1_q;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			ack_q <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			clr_q <= 1'b0;
		end else begin
			req_s1_q <= req_s1_d;
			req_s2_q <= req_s2_d;
			ack_q <= ack_d;
			ack_s1_q <= ack_s1_d;
			ack_s2_q <= ack_s2_d;
			clr_q <= clr_d;
		end
	end

	assign ack_out = ack_s2_q;
	assign far_clear = clr_q;

endmodule

/* verification/mbox_reset_hs_checker.sv */
/* Port checker for the mailbox reset handshake block.
   Assumes it is bound to every instance of mbox_reset_hs. */
`include "mbox_cfg.svh"

module mbox_reset_hs_checker #(
	parameter int BUF_WORDS = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Interrupt lines
	input wire logic fw_irq,
	input wire logic host_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// Bus and interrupt checks
	// ----------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire done = psel & penable & pready;

	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	pready_wait_a: assert property (psel && !penable |-> ##2 pready)
		else $error("pready not in second access cycle");
	pready_bus_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	err_map_a: assert property (
		done |-> pslverr == (paddr > `OFS_HOST_RD_WIN))
		else $error("pslverr wrong for address");
	err_data_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	fw_mask_a: assert property (
		done && pwrite && paddr == `OFS_FW_CSR && !pwdata[`BIT_IE]
		|-> ##2 !fw_irq) else $error("fw irq not masked");
	host_mask_a: assert property (
		done && pwrite && paddr == `OFS_HOST_CSR && !pwdata[`BIT_IE]
		|-> ##2 !host_irq) else $error("host irq not masked");
	irq_reset_a: assert property ($fell(reset) |-> !fw_irq && !host_irq)
		else $error("irq high after reset");

	cover property (done && pslverr);
	cover property ($rose(fw_irq));
	cover property ($rose(host_irq));
endmodule

bind mbox_reset_hs mbox_reset_hs_checker #(.BUF_WORDS(BUF_WORDS)) i_chk (
	.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .fw_irq, .host_irq);

/* verification/tb_top.sv */
/* Self-checking bench for the mailbox reset handshake over APB.
   Assumes the design and its checker are compiled before it. */
`include "mbox_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] M = 32'hFFFFFFFF;
	localparam logic [31:0] P = 32'h00FFFF00;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat, v;
	logic pready, pslverr, fw_irq, host_irq, rerr;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] fwq[$];
	logic [31:0] hq[$];

	always #10 ref_clk = ~ref_clk;

	mbox_reset_hs #(.BUF_WORDS(16)) i_dut (
		.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .fw_irq, .host_irq);

	// ----------------
	// Bus tasks
	// ----------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk("pslverr", {31'h0, rerr}, 32'h0);
	endtask

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("addr %h", a), rdat & m, e);
	endtask

	task automatic irqs(input logic f, h);
		repeat (3) @(posedge ref_clk);
		chk("fw_irq", {31'h0, fw_irq}, {31'h0, f});
		chk("host_irq", {31'h0, host_irq}, {31'h0, h});
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------
	// Sequence
	// ----------------
	initial begin
		void'($urandom(98969));
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rdm(`OFS_HOST_CSR, M, 32'h02000000);
		rdm(`OFS_FW_HOST_VIEW, M, 32'h02000000);
		rdm(`OFS_DEPTH, 32'hFFFF, 32'h0202);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
		apb(1'b1, 8'h44, 32'h0);
		chk("unmapped wr", {rerr, rdat[30:0]}, 32'h80000000);
		wr(`OFS_FW_CSR, 32'h09);
		wr(`OFS_HOST_CSR, 32'h09);
		repeat (2) begin
			v = $urandom;
			wr(`OFS_FW_WR_WIN, v);
			fwq.push_back(v);
		end
		v = $urandom;
		wr(`OFS_HOST_WR_WIN, v);
		hq.push_back(v);
		rdm(`OFS_FW_RD_WIN, M, fwq.pop_front());
		rdm(`OFS_HOST_RD_WIN, M, hq.pop_front());
		rdm(`OFS_FW_HOST_VIEW, P, 32'h00020100);
		rdm(`OFS_HOST_CSR, P, 32'h00010100);
		wr(`OFS_HOST_CSR, 32'h17);
		irqs(1'b1, 1'b0);
		rdm(`OFS_FW_HOST_VIEW, 32'h08, 32'h0);
		rdm(`OFS_HOST_CSR, 32'h08, 32'h0);
		rdm(`OFS_HOST_FW_VIEW, 32'h10, 32'h10);
		wr(`OFS_FW_CSR, 32'h12);
		irqs(1'b0, 1'b0);
		wr(`OFS_FW_WR_WIN, $urandom);
		rdm(`OFS_FW_RD_WIN, M, M);
		rdm(`OFS_FW_HOST_VIEW, P, 32'h00020100);
		fwq.delete();
		wr(`OFS_FW_CSR, 32'h30);
		rdm(`OFS_FW_CSR, 32'h20, 32'h20);
		// Next read shows the state ten cycles after the commit
		repeat (4) @(posedge ref_clk);
		rdm(`OFS_FW_CSR, P | 32'h20, 32'h0);
		rdm(`OFS_HOST_CSR, P, 32'h0);
		v = {16'h0, 8'($urandom_range(4, 16)), 8'($urandom_range(4, 16))};
		wr(`OFS_DEPTH, v);
		rdm(`OFS_FW_HOST_VIEW, 32'hFF000000, {v[7:0], 24'h0});
		rdm(`OFS_HOST_CSR, 32'hFF000000, {v[15:8], 24'h0});
		wr(`OFS_FW_CSR, 32'h0D);
		irqs(1'b0, 1'b1);
		rdm(`OFS_FW_HOST_VIEW, 32'h18, 32'h08);
		wr(`OFS_HOST_CSR, 32'h0F);
		irqs(1'b1, 1'b0);
		rdm(`OFS_HOST_FW_VIEW, 32'h18, 32'h08);
		v = $urandom;
		wr(`OFS_FW_WR_WIN, v);
		rdm(`OFS_FW_RD_WIN, M, v);
		rdm(`OFS_FW_HOST_VIEW, P, 32'h00010100);
		// Host status set again, then masked by the host enable
		wr(`OFS_FW_CSR, 32'h0D);
		irqs(1'b1, 1'b1);
		wr(`OFS_HOST_CSR, 32'h08);
		irqs(1'b1, 1'b0);
		rdm(`OFS_HOST_CSR, 32'h0A, 32'h0A);
		results();
	end

	// Cuts a hung handshake short
	initial begin
		repeat (3000) @(posedge ref_clk);
		fail_count++;
		results();
	end
endmodule
